// [inc/fsc_map.vh]
// Purpose: Offsets, field positions, reset values and timing for the
//          seek, sense and scan command engine.
// Assumes: 32-bit AXI4-Lite register words, 125 MHz clock.
// Notes:   Definitions only.
`ifndef FSC_MAP_VH
`define FSC_MAP_VH

`define FSC_OFS_DATA 8'h00
`define FSC_OFS_MSR 8'h04
`define FSC_OFS_CFG 8'h08
`define FSC_OFS_DISK 8'h0c
`define FSC_OFS_SCAN 8'h10
`define FSC_OFS_PTR 8'h14
`define FSC_OFS_DRV 8'h18

`define FSC_OP_SEEK 8'h0f
`define FSC_OP_SENSE_INT 8'h08
`define FSC_OP_SENSE_DRV 8'h04
`define FSC_OP_SCAN_LE 5'h19
`define FSC_OP_INVALID 8'h80

`define FSC_CFG_ETR 0
`define FSC_CFG_NON_DMA 1
`define FSC_CFG_SRT_LO 4
`define FSC_CFG_MNT_LO 8

`define FSC_MSR_RQM 7
`define FSC_MSR_DIO 6
`define FSC_MSR_NDMA 5
`define FSC_MSR_CB 4

`define FSC_ST0_READY_TRUE 3'h6
`define FSC_ST0_SEEK_OK 3'h1
`define FSC_ST0_SEEK_BAD 3'h3

`define FSC_CLK_MHZ 125
`define FSC_MS_UNIT_US 1000
`define FSC_MS_CYCLES (`FSC_CLK_MHZ * `FSC_MS_UNIT_US)
`define FSC_RESET_CFG 32'h0000_0000

`endif

// [rtl/fsc_engine.v]
// Purpose: Seek, sense-drive, sense-interrupt and scan-low-or-equal
//          command engine of a floppy controller, AXI4-Lite slave.
// Assumes: Drive inputs are asynchronous and are synchronised here.
// Notes:   One millisecond tick paces the motor-on and step timers.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "fsc_map.vh"
`default_nettype none
module fsc_engine #(
    parameter MS_CYCLES = `FSC_MS_CYCLES
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] drive_ready,
    input wire [3:0] track_zero,
    output reg step_pulse,
    output reg step_inward,
    output wire irq
);
    localparam S_IDLE = 3'd0;
    localparam S_CMD = 3'd1;
    localparam S_MOTOR = 3'd2;
    localparam S_SCAN = 3'd3;
    localparam S_RESULT = 3'd4;

    reg [2:0] state;
    reg [31:0] cfg;
    reg [3:0] rdy_s1, rdy_s2, rdy_last, tz_s1, tz_s2;
    reg [7:0] cmd [0:3];
    reg [2:0] cmd_cnt;
    reg [7:0] res [0:6];
    reg [2:0] res_cnt, res_len;
    reg res_is_sense;
    reg [11:0] ptr [0:3];
    reg [11:0] target;
    reg [1:0] seek_drv;
    reg [3:0] seeking;
    reg seek_bad;
    reg seek_end_pend;
    reg [3:0] rdy_pend;
    reg auto_irq;
    reg [7:0] disk_byte;
    reg disk_valid;
    reg [1:0] scan_st;
    reg [31:0] ms_cnt;
    reg ms_tick;
    reg [7:0] tmr;
    reg [4:0] step_cnt;
    reg step_wait_end;
    reg aw_hold, w_hold;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [7:0] drive_rep;
    integer i;

    wire extended_track_range = cfg[`FSC_CFG_ETR];
    wire non_dma = cfg[`FSC_CFG_NON_DMA];
    wire [3:0] srt = cfg[`FSC_CFG_SRT_LO+3:`FSC_CFG_SRT_LO];
    wire [6:0] mnt = cfg[`FSC_CFG_MNT_LO+6:`FSC_CFG_MNT_LO];
    wire [7:0] mnt_ms = (mnt == 7'h00) ? 8'h80 : {1'b0, mnt};
    wire [4:0] srt_ms = 5'h10 - {1'b0, srt};
    wire do_write = aw_hold && w_hold && !s_axi_bvalid;
    wire do_read = s_axi_arvalid && !s_axi_rvalid;
    wire wr_data = do_write && aw_addr == `FSC_OFS_DATA;
    wire rd_data = do_read && s_axi_araddr == `FSC_OFS_DATA;
    wire [7:0] wbyte = w_data[7:0];
    wire [1:0] sel_drv = cmd[1][1:0];
    wire int_pend = seek_end_pend || (rdy_pend != 4'h0);
    wire rqm = state == S_IDLE || state == S_CMD || state == S_RESULT ||
        (state == S_SCAN && non_dma);
    wire [7:0] main_state_register = {rqm, state == S_RESULT, non_dma,
        state != S_IDLE, seeking};
    wire [1:0] rdy_drv = rdy_pend[0] ? 2'd0 : rdy_pend[1] ? 2'd1 :
        rdy_pend[2] ? 2'd2 : 2'd3;
    wire [11:0] cur_ptr = ptr[seek_drv];
    wire seek_done = cur_ptr == target;

    assign s_axi_awready = !aw_hold;
    assign s_axi_wready = !w_hold;
    assign s_axi_arready = !s_axi_rvalid;
    assign irq = int_pend || auto_irq;

    function [2:0] cmd_len;
        input [7:0] op;
        input e;
        begin
            if (op == `FSC_OP_SEEK)
                cmd_len = e ? 3'd4 : 3'd3;
            else if (op == `FSC_OP_SENSE_DRV)
                cmd_len = 3'd2;
            else if (op[4:0] == `FSC_OP_SCAN_LE)
                cmd_len = 3'd1; // Scan geometry bytes are not modelled.
            else
                cmd_len = 3'd1;
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            rdy_s1 <= 4'h0;
            rdy_s2 <= 4'h0;
            tz_s1 <= 4'h0;
            tz_s2 <= 4'h0;
        end else begin
            rdy_s1 <= drive_ready;
            rdy_s2 <= rdy_s1;
            tz_s1 <= track_zero;
            tz_s2 <= tz_s1;
        end
    end

    // The millisecond tick keeps the step and motor timers narrow.
    always @(posedge aclk) begin
        if (!aresetn || ms_cnt == MS_CYCLES - 1) begin
            ms_cnt <= 32'h0;
            ms_tick <= aresetn;
        end else begin
            ms_cnt <= ms_cnt + 32'h1;
            ms_tick <= 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h0;
        end else begin
            if (s_axi_awvalid && !aw_hold) begin
                aw_hold <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && !w_hold) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == `FSC_OFS_DATA ||
                    aw_addr == `FSC_OFS_CFG || aw_addr == `FSC_OFS_DISK ||
                    aw_addr == `FSC_OFS_DRV) ? 2'b00 : 2'b10;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case ({s_axi_araddr[7:2], 2'b00})
                    `FSC_OFS_DATA: s_axi_rdata <= (state == S_RESULT) ?
                        {24'h0, res[res_cnt]} : 32'h0;
                    `FSC_OFS_MSR: s_axi_rdata <= {24'h0, main_state_register};
                    `FSC_OFS_CFG: s_axi_rdata <= cfg;
                    `FSC_OFS_SCAN: s_axi_rdata <= {30'h0, scan_st};
                    `FSC_OFS_PTR: s_axi_rdata <= {20'h0, cur_ptr};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= S_IDLE;
            cfg <= `FSC_RESET_CFG;
            cmd_cnt <= 3'd0;
            res_cnt <= 3'd0;
            res_len <= 3'd0;
            res_is_sense <= 1'b0;
            target <= 12'h0;
            seek_drv <= 2'd0;
            seeking <= 4'h0;
            seek_bad <= 1'b0;
            seek_end_pend <= 1'b0;
            rdy_pend <= 4'h0;
            rdy_last <= 4'h0;
            auto_irq <= 1'b0;
            disk_byte <= 8'h00;
            disk_valid <= 1'b0;
            scan_st <= 2'b00;
            tmr <= 8'h00;
            step_cnt <= 5'h0;
            step_wait_end <= 1'b0;
            step_pulse <= 1'b0;
            step_inward <= 1'b0;
            drive_rep <= 8'h00;
            for (i = 0; i < 4; i = i + 1)
                ptr[i] <= 12'h0;
            for (i = 0; i < 7; i = i + 1)
                res[i] <= 8'h00;
            for (i = 0; i < 4; i = i + 1)
                cmd[i] <= 8'h00;
        end else begin
            step_pulse <= 1'b0;
            if (do_write && aw_addr == `FSC_OFS_CFG)
                cfg <= w_data;
            if (do_write && aw_addr == `FSC_OFS_DRV)
                drive_rep <= wbyte;
            if (do_write && aw_addr == `FSC_OFS_DISK) begin
                disk_byte <= wbyte;
                disk_valid <= 1'b1;
            end
            // Ready changes are polled against the last seen level.
            rdy_last <= rdy_s2;
            if (rdy_s2 != rdy_last)
                rdy_pend <= rdy_pend | (rdy_s2 ^ rdy_last);
            if (wr_data || rd_data)
                auto_irq <= 1'b0;
            case (state)
                S_IDLE, S_CMD: if (wr_data) begin
                    cmd[cmd_cnt[1:0]] <= wbyte;
                    if ((cmd_cnt == 3'd0 &&
                        cmd_len(wbyte, extended_track_range) == 3'd1) ||
                        (cmd_cnt != 3'd0 &&
                        cmd_cnt + 3'd1 == cmd_len(cmd[0], extended_track_range))) begin
                        cmd_cnt <= 3'd0;
                        res_cnt <= 3'd0;
                        if (cmd_cnt == 3'd0 &&
                            wbyte == `FSC_OP_SENSE_INT) begin
                            res_is_sense <= 1'b1;
                            state <= S_RESULT;
                            if (!int_pend) begin
                                res[0] <= `FSC_OP_INVALID;
                                res_len <= 3'd1;
                            end else if (seek_end_pend) begin
                                res[0] <= {seek_bad ? `FSC_ST0_SEEK_BAD :
                                    `FSC_ST0_SEEK_OK, 3'b000,
                                    seek_drv};
                                res[1] <= cur_ptr[7:0];
                                res[2] <= {cur_ptr[11:8], 4'h0};
                                res_len <= extended_track_range ? 3'd3 : 3'd2;
                            end else begin
                                res[0] <= {`FSC_ST0_READY_TRUE, 3'b000,
                                    rdy_drv};
                                res[1] <= ptr[rdy_drv][7:0];
                                res[2] <= {ptr[rdy_drv][11:8], 4'h0};
                                res_len <= extended_track_range ? 3'd3 : 3'd2;
                            end
                        end else if (cmd_cnt == 3'd0 &&
                            wbyte[4:0] == `FSC_OP_SCAN_LE) begin
                            res_is_sense <= 1'b0;
                            scan_st <= 2'b10;
                            state <= S_SCAN;
                        end else if (cmd_cnt != 3'd0 &&
                            cmd[0] == `FSC_OP_SEEK) begin
                            seek_drv <= sel_drv;
                            target <= extended_track_range ? {wbyte[7:4], cmd[2]} :
                                {4'h0, (cmd_cnt == 3'd2) ? wbyte : cmd[2]};
                            seeking[sel_drv] <= 1'b1;
                            seek_bad <= 1'b0;
                            tmr <= mnt_ms;
                            state <= S_MOTOR;
                        end else if (cmd_cnt != 3'd0 &&
                            cmd[0] == `FSC_OP_SENSE_DRV) begin
                            res[0] <= {drive_rep[7:3], wbyte[2:0]};
                            res_len <= 3'd1;
                            res_is_sense <= 1'b0;
                            state <= S_RESULT;
                        end else begin
                            res[0] <= `FSC_OP_INVALID;
                            res_len <= 3'd1;
                            res_is_sense <= 1'b0;
                            state <= S_RESULT;
                        end
                    end else begin
                        cmd_cnt <= cmd_cnt + 3'd1;
                        state <= S_CMD;
                    end
                end
                S_MOTOR: if (ms_tick) begin
                    if (tmr <= 8'h01) begin
                        state <= S_IDLE;
                        step_cnt <= srt_ms;
                        // Direction settles a full interval before a step.
                        step_inward <= target > cur_ptr;
                    end else
                        tmr <= tmr - 8'h01;
                end
                S_SCAN: begin
                    // Each host byte that finds a disk byte pending meets the latest one; other host bytes are ignored.
                    if (wr_data && disk_valid) begin
                        disk_valid <= 1'b0;
                        if (non_dma)
                            auto_irq <= 1'b1;
                        if (disk_byte > wbyte)
                            scan_st <= 2'b01;
                        else if (disk_byte < wbyte && scan_st == 2'b10)
                            scan_st <= 2'b00;
                    end else if (do_write && aw_addr == `FSC_OFS_MSR) begin
                        res[0] <= {3'b000, 3'b000, cmd[0][1:0]};
                        res[1] <= 8'h00;
                        res[2] <= {4'h0, scan_st, 2'b00};
                        res[3] <= 8'h00;
                        res[4] <= 8'h00;
                        res[5] <= 8'h00;
                        res[6] <= 8'h00;
                        res_len <= 3'd7;
                        auto_irq <= 1'b1;
                        state <= S_RESULT;
                    end
                end
                S_RESULT: if (rd_data) begin
                    if (res_is_sense && res_cnt == 3'd0) begin
                        if (seek_end_pend)
                            seek_end_pend <= 1'b0;
                        else
                            // A change in the same cycle keeps it pending.
                            rdy_pend[rdy_drv] <= rdy_s2[rdy_drv] ^
                                rdy_last[rdy_drv];
                    end
                    if (res_cnt + 3'd1 >= res_len)
                        state <= S_IDLE;
                    else
                        res_cnt <= res_cnt + 3'd1;
                end
                default: state <= S_IDLE;
            endcase
            // Background stepping runs in every phase except S_MOTOR.
            if (seeking != 4'h0 && state != S_MOTOR && ms_tick) begin
                step_inward <= target > cur_ptr;
                if (step_cnt > 5'h1)
                    step_cnt <= step_cnt - 5'h1;
                else begin
                    step_cnt <= srt_ms;
                    if (step_wait_end || seek_done) begin
                        seeking <= 4'h0;
                        step_wait_end <= 1'b0;
                        seek_end_pend <= 1'b1;
                    end else if (target < cur_ptr && tz_s2[seek_drv]) begin
                        ptr[seek_drv] <= 12'h0;
                        seek_bad <= target != 12'h0;
                        step_wait_end <= 1'b1;
                    end else begin
                        step_pulse <= 1'b1;
                        ptr[seek_drv] <= (target > cur_ptr) ?
                            cur_ptr + 12'h1 : cur_ptr - 12'h1;
                        step_wait_end <= (target > cur_ptr) ?
                            (cur_ptr + 12'h1 == target) :
                            (cur_ptr - 12'h1 == target);
                    end
                end
            end
        end
    end
endmodule // fsc_engine
`default_nettype wire

// [tb/fsc_drive_model.sv]
// Purpose: Behavioural drive that follows the step and direction outputs.
// Assumes: Only drive 0 is ever stepped; the others stay parked.
// Notes: Outward steps at track 0 leave the head where it is.
`timescale 1ns/10ps
`default_nettype none
module fsc_drive_model #(
    parameter logic [3:0] READY_MASK = 4'h1
) (
    input wire logic aclk,
    input wire logic step_pulse,
    input wire logic step_inward,
    output logic [3:0] drive_ready,
    output logic [3:0] track_zero
);
    int pos = 0;
    always @(posedge aclk) begin
        if (step_pulse && step_inward) begin
            pos <= pos + 1;
        end else if (step_pulse && pos > 0) begin
            pos <= pos - 1;
        end
    end
    assign drive_ready = READY_MASK;
    assign track_zero = {3'h0, pos == 0};
endmodule // fsc_drive_model
`default_nettype wire

// [tb/fsc_engine_sva.sv]
// Purpose: Port level checks on the seek, sense and scan command engine.
// Assumes: One clock domain with a synchronous active low reset.
// Notes: Bound to every engine instance, sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fsc_engine_sva #(
    parameter MS_CYCLES = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] drive_ready,
    input wire [3:0] track_zero,
    input wire step_pulse,
    input wire step_inward,
    input wire irq
);
    // Cycles since the last step, saturating so it never wraps.
    int gap;
    always @(posedge aclk) begin
        if (!aresetn || step_pulse) begin
            gap <= 0;
        end else if (gap < MS_CYCLES) begin
            gap <= gap + 1;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_answer;
        s_wr_both |-> ##2 s_axi_bvalid;
    endproperty
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_aw_busy;
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
    endproperty
    property p_slverr;
        s_rd_take ##0 (s_axi_araddr > 8'h18) |=>
            s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
    endproperty
    property p_step_gap;
        step_pulse |-> gap >= MS_CYCLES - 1;
    endproperty
    property p_step_dir;
        step_pulse |-> $stable(step_inward);
    endproperty
    property p_reset_quiet;
        $rose(aresetn) |-> !step_pulse && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("late bvalid");
    a_rd_answer: assert property (p_rd_answer) else $error("late rvalid");
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
    a_aw_busy: assert property (p_aw_busy) else $error("awready held");
    a_slverr: assert property (p_slverr) else $error("no slave error");
    a_step_gap: assert property (p_step_gap) else $error("steps too close");
    a_step_dir: assert property (p_step_dir) else $error("direction moved");
    a_reset_quiet: assert property (p_reset_quiet) else $error("reset busy");
endmodule // fsc_engine_sva
bind fsc_engine fsc_engine_sva #(.MS_CYCLES(MS_CYCLES)) sva_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .drive_ready(drive_ready), .track_zero(track_zero),
    .step_pulse(step_pulse), .step_inward(step_inward), .irq(irq));
`default_nettype wire

// [tb/test_fdc_seek_sense_scan_cmds.sv]
// Purpose: Self-checking bench for the seek, sense and scan engine.
// Assumes: One millisecond shortened to four clock cycles.
// Notes: Random targets and scan bytes from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
module test_fdc_seek_sense_scan_cmds;
    localparam int MS = 4;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, dir_exp;
    logic [7:0] awaddr = 0, araddr = 0, h, d;
    logic [31:0] wdata = 0, rd, v;
    logic [1:0] rs;
    logic [11:0] cur = 0, t1;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] drdy, tz;
    wire bvalid, rvalid, awready, wready, arready, step, inward, irq;
    int n_mismatch = 0, checked = 0, cyc = 0, n_steps = 0;
    int first_step, last_step, gap_exp;
    fsc_engine #(.MS_CYCLES(MS)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_ready(drdy),
        .track_zero(tz), .step_pulse(step), .step_inward(inward), .irq(irq));
    fsc_drive_model drv_u (.aclk(aclk), .step_pulse(step),
        .step_inward(inward), .drive_ready(drdy), .track_zero(tz));
    initial forever #4 aclk = ~aclk;
    task automatic results();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dat;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw = 1;
                awvalid <= 0;
            end
            if (wvalid && wready) begin
                w = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready <= 0;
        rs = bresp;
    endtask
    task automatic rd_(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        rready <= 0;
        rd = rdata;
        rs = rresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
        rd_(a);
        chk(rd & m, e);
    endtask
    function automatic logic [31:0] scan_exp(input logic [7:0] dk, hs);
        return dk == hs ? 32'h8 : (dk < hs ? 32'h0 : 32'h4);
    endfunction
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (step) begin
            if (n_steps == 0) first_step <= cyc;
            else chk(cyc - last_step, gap_exp);
            chk(inward, dir_exp);
            last_step <= cyc;
            n_steps <= n_steps + 1;
        end
    end
    task automatic seek(input logic [11:0] t, input logic extended_track_range, input int iv, mnt);
        int t_cmd, k;
        n_steps = 0;
        gap_exp = iv;
        dir_exp = t > cur;
        wr(0, 32'h0f);
        wr(0, 32'h00);
        wr(0, {24'h0, t[7:0]});
        if (extended_track_range) wr(0, {24'h0, t[11:8], 4'h0});
        t_cmd = cyc;
        rdc(8'h04, 32'h41, 32'h01);
        do @(posedge aclk); while (n_steps == 0);
        k = first_step - t_cmd;
        chk(k > (mnt - 1) * MS + iv && k <= mnt * MS + iv, 1);
        rdc(8'h04, 32'h80, 32'h80);
        k = 0;
        do @(posedge aclk); while (irq !== 1 && ++k < 5000);
        chk(irq, 1);
        k = cyc - last_step;
        chk(k >= iv - 1 && k <= iv + 2, 1);
        chk(n_steps, t > cur ? 32'(t - cur) : 32'(cur - t));
        rdc(8'h14, 32'hfff, {20'h0, t});
        wr(0, 32'h08);
        rdc(0, 32'hff, 32'h20);
        @(posedge aclk);
        chk(irq, 0);
        rdc(0, 32'hff, {24'h0, t[7:0]});
        if (extended_track_range) rdc(0, 32'hff, {24'h0, t[11:8], 4'h0});
        cur = t;
    endtask
    initial begin
        void'($urandom(24));
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (10) @(posedge aclk);
        chk(irq, 1);
        wr(0, 32'h08);
        rdc(0, 32'hff, 32'hc0);
        @(posedge aclk);
        chk(irq, 0);
        rdc(0, 32'hff, 32'h00);
        wr(0, 32'h08);
        rdc(0, 32'hff, 32'h80);
        wr(8'h08, 32'h03c0);
        t1 = 12'(2 + $urandom % 10);
        seek(t1, 0, 16, 3);
        seek(12'(1 + $urandom % (t1 - 1)), 0, 16, 3);
        wr(8'h08, 32'h01f1);
        seek(12'h102, 1, 4, 1);
        v = $urandom;
        wr(8'h18, v);
        wr(0, 32'h04);
        wr(0, {29'h0, v[10:8]});
        rdc(0, 32'hff, {24'h0, v[7:3], v[10:8]});
        @(posedge aclk);
        chk(irq, 0);
        for (int i = 0; i < 3; i++) begin
            h = 8'h01 + 8'($urandom % 254);
            d = h + 8'(i) - 8'h01;
            if (i == 2) wr(8'h08, 32'h01f3);
            wr(0, 32'h19);
            wr(8'h0c, {24'h0, d});
            wr(0, {24'h0, h});
            @(posedge aclk);
            chk(irq, i == 2);
            wr(8'h04, 32'h0);
            @(posedge aclk);
            chk(irq, 1);
            rdc(8'h10, 32'h03, scan_exp(d, h) >> 2);
            rd_(0);
            @(posedge aclk);
            chk(irq, 0);
            rd_(0);
            rdc(0, 32'h0c, scan_exp(d, h));
            repeat (4) rd_(0);
        end
        rd_(8'h40);
        chk(rs, 2'b10);
        chk(rd, 32'h0);
        wr(8'h40, 32'h5a);
        chk(rs, 2'b10);
        results();
    end
    initial begin
        #(8 * 20000);
        n_mismatch++;
        results();
    end
endmodule // test_fdc_seek_sense_scan_cmds
`default_nettype wire
